// File: dv/flash_programming_port_tb_top.sv
/*
  Bench joining both ends through fpp_if, checked against a byte model.
  Assumes the parallel step raises the high-voltage and reset pins itself.
*/
`timescale 1ns/100ps
module flash_programming_port_tb_top;
  import fpp_pkg::*;
  localparam logic [7:0] MID [3] = '{8'h3C, 8'h96, 8'h0F};  // arbitrary
  localparam logic [3:0] UNDEF [8] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB};
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       req_i = 1'b0;
  fpp_op_type op_i = OP_PAR_STEP;
  logic [3:0] cmd_i = '0;
  logic [7:0] wdata_i = '0;
  logic       strobe_i = 1'b0;
  logic       read_i = 1'b0;
  logic       pulse_i = 1'b0;
  logic       wait_i = 1'b0;
  logic       ack_o, hbusy, dbusy, par_m, ser_m;
  logic [7:0] rdata_o, got, wd, code_m [4096], urow [32], fuse_m, pkt [11];
  logic [6:0] pg;
  logic [11:0] a;
  int         num_errors = 0;
  int         checks = 0;
  always #2 clk_i = ~clk_i;
  fpp_if u_fpp_if ();
  fpp_dev #(.P_IDLE_CYC(600), .P_ERASE_CYC(100), .P_PAGE_CYC(60), .MFR_ID0(MID[0]),
    .MFR_ID1(MID[1]), .MFR_ID2(MID[2])) u_fpp_dev (.clk_i(clk_i), .rst_i(rst_i),
    .pin(u_fpp_if), .par_mode_o(par_m), .ser_mode_o(ser_m), .busy_o(dbusy));
  fpp_host #(.P_SCLK_CYC(64)) u_fpp_host (.clk_i(clk_i), .rst_i(rst_i), .pin(u_fpp_if),
    .req_i(req_i), .op_i(op_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .strobe_i(strobe_i),
    .read_i(read_i), .pulse_i(pulse_i), .wait_i(wait_i), .ack_o(ack_o), .rdata_o(rdata_o),
    .busy_o(hbusy));
  fpp_assertions u_fpp_assertions (.clk_i(clk_i),
    .rst_i(rst_i), .cmd_code(u_fpp_if.cmd_code), .hv_on(u_fpp_if.hv_on),
    .rst_pin(u_fpp_if.rst_pin), .osc_in(u_fpp_if.osc_in), .wr_strobe_n(u_fpp_if.wr_strobe_n),
    .dev_data_oe(u_fpp_if.dev_data_oe), .busy_pull_oe(u_fpp_if.busy_pull_oe),
    .sck(u_fpp_if.sck), .mosi(u_fpp_if.mosi), .mosi_oe(u_fpp_if.mosi_oe),
    .miso(u_fpp_if.miso), .miso_oe(u_fpp_if.miso_oe));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] exp, input logic [7:0] act);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  // request held until ack is sampled; read data taken at that same edge
  task automatic step(input fpp_op_type op, input logic [3:0] c, input logic [7:0] d,
                      input logic s, input logic r, input logic p);
    int n;
    n = 0;
    @(posedge clk_i);
    op_i <= op;
    {req_i, cmd_i, wdata_i, strobe_i, read_i, pulse_i} <= {1'b1, c, d, s, r, p};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 8000);
    got = rdata_o;
    req_i <= 1'b0;
    if (n >= 8000) num_errors++;
  endtask
  task automatic par_rd(input logic [3:0] c, input logic [7:0] exp);
    step(OP_PAR_STEP, c, 8'h00, 1'b0, 1'b1, 1'b1);
    cmp(exp, got);
  endtask
  task automatic load(input logic [6:0] p);
    step(OP_PAR_STEP, CMD_LOAD_PG, {1'b0, p}, 1'b0, 1'b0, 1'b1);
  endtask
  // waits for the internally timed burn to start and end
  task automatic burn();
    int n;
    n = 0;
    while (dbusy !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    while (dbusy !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) num_errors++;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h003e2834));
    fuse_m = FUSE_RST;
    foreach (code_m[i]) code_m[i] = ERASED;
    foreach (urow[i]) urow[i] = ERASED;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    par_rd(CMD_FUSE_RD, fuse_m);
    cmp(8'h02, {5'h0, hbusy, par_m, ser_m});
    pg = 7'($urandom_range(127, 2));
    load(pg);
    for (int i = 0; i < 3; i++) begin
      wd = 8'($urandom);
      code_m[{pg, 5'(i)}] = wd;
      step(OP_PAR_STEP, CMD_CODE_WR, wd, 1'b1, 1'b0, 1'b1);
    end
    burn();
    load(pg);
    for (int i = 0; i < 3; i++) par_rd(CMD_CODE_RD, code_m[{pg, 5'(i)}]);
    load(PG_USER);
    urow[0] = 8'($urandom);
    step(OP_PAR_STEP, CMD_SIG_WR, urow[0], 1'b1, 1'b0, 1'b1);
    burn();
    load(PG_USER);
    par_rd(CMD_SIG_RD, urow[0]);
    load(PG_MFR);
    for (int i = 0; i < 3; i++) par_rd(CMD_SIG_RD, MID[i]);
    wd = 8'($urandom) & 8'hFC;
    fuse_m = wd | FUSE_RSVD;
    step(OP_PAR_STEP, CMD_FUSE_WR, wd, 1'b1, 1'b0, 1'b0);
    burn();
    par_rd(CMD_FUSE_RD, fuse_m);
    // the host waits on the busy pin itself here
    wait_i <= 1'b1;
    step(OP_PAR_STEP, CMD_ERASE, 8'h00, 1'b1, 1'b0, 1'b0);
    wait_i <= 1'b0;
    cmp(8'h00, {7'h0, dbusy});
    foreach (code_m[i]) code_m[i] = ERASED;
    if (fuse_m[FUSE_UROW] == 1'b0) urow[0] = ERASED;
    fuse_m[1:0] = LOCK_OPEN;
    load(pg);
    par_rd(CMD_CODE_RD, ERASED);
    load(PG_USER);
    par_rd(CMD_SIG_RD, urow[0]);
    par_rd(CMD_FUSE_RD, fuse_m);
    foreach (UNDEF[i]) par_rd(UNDEF[i], PULL_HI);
    step(OP_SER_ENTER, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    cmp(8'h01, {5'h0, hbusy, par_m, ser_m});
    a = 12'($urandom);
    wd = 8'($urandom);
    code_m[a] = wd;
    // byte write, byte read back, then the header of a page read of that page
    pkt = '{8'h02, {4'h0, a[11:8]}, a[7:0], wd, 8'h00, {4'h0, a[11:8]}, a[7:0], 8'hFF,
            8'h01, {4'h0, a[11:8]}, {a[7:5], 5'h00}};
    foreach (pkt[i]) begin
      step(OP_SER_BYTE, 4'h0, pkt[i], 1'b0, 1'b0, 1'b0);
      if (i == 7) cmp(code_m[a], got);
    end
    for (int i = 0; i < ROW_BYTES; i++) begin
      step(OP_SER_BYTE, 4'h0, 8'hFF, 1'b0, 1'b0, 1'b0);
      cmp(code_m[{a[11:5], 5'(i)}], got);
    end
    step(OP_EXIT, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    cmp(8'h00, {5'h0, hbusy, par_m, ser_m});
    finish_test();
  end
endmodule

// File: dv/fpp_assertions.sv
/*
  Concurrent checks on the pins between the two ends of fpp_if.
  Assumes clk_i and rst_i are shared by both ends and the short-sim counts.
*/
`timescale 1ns/100ps
module fpp_assertions
  import fpp_pkg::*;
#(
  parameter int P_ERASE_CYC = 100,
  parameter int P_PAGE_CYC  = 60
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [3:0] cmd_code,
  input wire logic       hv_on,
  input wire logic       rst_pin,
  input wire logic       osc_in,
  input wire logic       wr_strobe_n,
  input wire logic       dev_data_oe,
  input wire logic       busy_pull_oe,
  input wire logic       sck,
  input wire logic       mosi,
  input wire logic       mosi_oe,
  input wire logic       miso,
  input wire logic       miso_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [19:0] bcnt_r;
  logic        rd_code;
  int          blen;
  assign rd_code = cmd_code == CMD_CODE_RD || cmd_code == CMD_SIG_RD || cmd_code == CMD_FUSE_RD;
  assign blen    = int'(bcnt_r);
  // one cycle of slack either way: the pin is registered after the timer
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_pull_oe) begin
      bcnt_r <= '0;
    end else begin
      bcnt_r <= bcnt_r + 20'h1;
    end
  end
  chk_busy_par_only: assert property ((!hv_on)[*8] |-> !busy_pull_oe)
    else $error("busy pulled outside parallel mode");
  chk_burn_length: assert property ($fell(busy_pull_oe) |->
    (blen >= P_PAGE_CYC - 1 && blen <= P_PAGE_CYC + 1) ||
    (blen >= P_ERASE_CYC - 1 && blen <= P_ERASE_CYC + 1))
    else $error("busy length wrong");
  chk_strobe_quiet: assert property ($rose(wr_strobe_n) && hv_on &&
    cmd_code == CMD_CODE_WR && !busy_pull_oe |-> !busy_pull_oe[*8])
    else $error("page burn began before quiet time");
  chk_fuse_drive: assert property ((hv_on && rst_pin && cmd_code == CMD_FUSE_RD)[*8]
    |-> dev_data_oe) else $error("fuse read not driven");
  chk_undef_float: assert property ((!rd_code)[*8] |-> !dev_data_oe)
    else $error("data port driven without read code");
  chk_cmd_hold: assert property (!wr_strobe_n ##1 !wr_strobe_n |-> $stable(cmd_code))
    else $error("command changed under strobe");
  chk_pulse_width: assert property ($rose(osc_in) && hv_on |-> osc_in[*8])
    else $error("oscillator pulse too short");
  chk_mosi_at_fall: assert property ($fell(sck) |-> $stable(mosi))
    else $error("mosi moved at sampling edge");
  chk_miso_settled: assert property ((!sck)[*8] ##1 !sck |-> $stable(miso) || !miso_oe)
    else $error("miso moved away from rising edge");
  chk_entry_order: assert property ($rose(rst_pin) && !hv_on && mosi_oe |->
    !sck && !miso_oe) else $error("serial entry out of order");
  chk_exit_order: assert property ($fell(rst_pin) && !hv_on |-> !osc_in && mosi_oe)
    else $error("serial exit out of order");
  cov_burn: cover property ($rose(busy_pull_oe));
  cov_fuse_rd: cover property (dev_data_oe && cmd_code == CMD_FUSE_RD);
  cov_ser_bit: cover property ($fell(sck) && !hv_on);
endmodule

// File: hdl/fpp_dev.sv
/*
  Flash device end: parallel programming decoder, page buffer, timed
  erase/write, signature rows, fuse byte and the serial byte shifter.
  Assumes every pin comes from outside clk_i; each is synchronised here.
*/
// Summary of operation
// - address is page[11:5] plus offset[4:0]
// - keep writable user row, read-only maker row
// - pull busy low only during erase/write
// - command code is four pins, bit3 first
// - any reset pin edge clears the offset
// - load page on oscillator fall, clear offset
// - oscillator pulse on code/sig read/write advances offset at its fall
// - strobe captures byte; 150 us quiet starts write
// - erase and fuse write 4 ms, page 2 ms
// - erase fills FF, user row if enabled, unlocks
// - programmer erases with code 0001 and strobe
// - programmer loads page zero before row write
// - page 00 reads user row, 01 maker row
// - user row read drives byte at offset
// - fuse byte layout bits 7..4 and 1..0
// - fuse write with code 1111 and strobe
// - code 0011 drives the fuse byte out
// - programmer power-up: sck low, wait, reset high
// - serial entry: sck low, release, reset high
// - serial exit: osc low, reset low, release
// - serial MSB first, out on rise, in on fall
// - serial packets are 4 or 35 bytes
`timescale 1ns/100ps
module fpp_dev
  import fpp_pkg::*;
#(
  parameter int         P_IDLE_CYC  = IDLE_CYC,
  parameter int         P_ERASE_CYC = ERASE_CYC,
  parameter int         P_PAGE_CYC  = PAGE_CYC,
  parameter logic [7:0] MFR_ID0     = 8'h5A,  // arbitrary
  parameter logic [7:0] MFR_ID1     = 8'hA5,  // arbitrary
  parameter logic [7:0] MFR_ID2     = 8'hFF   // arbitrary
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fpp_if.dev        pin,
  output wire logic par_mode_o,
  output wire logic ser_mode_o,
  output wire logic busy_o
);
  typedef struct packed {
    fpp_pins_type                  s1;
    fpp_pins_type                  s2;
    logic                          osc_q;
    logic                          stb_q;
    logic                          rst_q;
    logic                          sck_q;
    logic [CODE_BYTES-1:0][7:0]    code;
    logic [ROW_BYTES-1:0][7:0]     urow;
    logic [ROW_BYTES-1:0][7:0]     pbuf;
    logic [ROW_BYTES-1:0]          pmask;
    logic [PAGE_W-1:0]             page;
    logic [OFF_W-1:0]              off;
    logic [7:0]                    fuse;
    logic [TMR_W-1:0]              busy_cnt;
    logic [TMR_W-1:0]              idle_cnt;
    logic                          pend;
    logic                          pend_sig;
    logic [7:0]                    dout;
    logic                          dout_oe;
    logic                          busy_oe;
    logic                          par;
    logic                          ser;
    logic [2:0]                    bitc;
    logic [5:0]                    bytec;
    logic [7:0]                    rx;
    logic [7:0]                    tx;
    logic [7:0]                    hdr;
    logic [ADDR_W-1:0]             saddr;
    logic                          miso;
    logic                          miso_oe;
  } fpp_dev_st_type;

  fpp_dev_st_type st_r;
  fpp_dev_st_type st_nxt;
  fpp_pins_type   pins_in;
  fpp_pins_type   p;

  assign pins_in = {pin.cmd_code, pin.data_lvl, pin.osc_in, pin.wr_strobe_n, pin.rst_pin,
                    pin.hv_on, pin.sck, pin.mosi_lvl};
  assign p = st_r.s2;

  assign pin.dev_data     = st_r.dout;
  assign pin.dev_data_oe  = st_r.dout_oe;
  assign pin.busy_pull_oe = st_r.busy_oe;
  assign pin.miso         = st_r.miso;
  assign pin.miso_oe      = st_r.miso_oe;
  assign par_mode_o       = st_r.par;
  assign ser_mode_o       = st_r.ser;
  assign busy_o           = st_r.busy_oe;

  function automatic logic [7:0] mfr_byte(input logic [OFF_W-1:0] idx);
    case (idx)
      5'h00:   mfr_byte = MFR_ID0;
      5'h01:   mfr_byte = MFR_ID1;
      5'h02:   mfr_byte = MFR_ID2;
      default: mfr_byte = ERASED;
    endcase
  endfunction

  always_comb begin
    logic              par;
    logic              ser;
    logic              osc_fall;
    logic              stb_rise;
    logic              sck_rise;
    logic              sck_fall;
    logic [7:0]        rxb;
    logic [ADDR_W-1:0] a;
    logic [5:0]        last;
    par      = p.hv & p.rst;
    ser      = !p.hv & p.rst;
    osc_fall = st_r.osc_q & !p.osc;
    stb_rise = !st_r.stb_q & p.stb_n;
    sck_rise = !st_r.sck_q & p.sck;
    sck_fall = st_r.sck_q & !p.sck;
    rxb      = 8'h00;
    a        = st_r.saddr;
    last     = 6'h00;
    st_nxt       = st_r;
    st_nxt.s1    = pins_in;
    st_nxt.s2    = st_r.s1;
    st_nxt.osc_q = p.osc;
    st_nxt.stb_q = p.stb_n;
    st_nxt.rst_q = p.rst;
    st_nxt.sck_q = p.sck;
    st_nxt.par   = par;
    st_nxt.ser   = ser;

    if (st_r.busy_cnt != '0) begin
      st_nxt.busy_cnt = st_r.busy_cnt - 1'b1;
    end
    if (st_r.rst_q != p.rst) begin
      st_nxt.off = '0;
    end

    // quiet time after the last strobe, then the buffered page is burned
    if (st_r.pend && st_r.busy_cnt == '0) begin
      if (st_r.idle_cnt != '0) begin
        st_nxt.idle_cnt = st_r.idle_cnt - 1'b1;
      end else begin
        for (int i = 0; i < ROW_BYTES; i++) begin
          if (st_r.pmask[i]) begin
            if (st_r.pend_sig) begin
              st_nxt.urow[i] = st_r.pbuf[i];
            end else begin
              st_nxt.code[{st_r.page, OFF_W'(i)}] = st_r.pbuf[i];
            end
          end
        end
        st_nxt.pend     = 1'b0;
        st_nxt.pmask    = '0;
        st_nxt.busy_cnt = TMR_W'(P_PAGE_CYC);
      end
    end

    if (par && osc_fall) begin
      if (p.cmd == CMD_LOAD_PG) begin
        st_nxt.page = p.data[PAGE_W-1:0];
        st_nxt.off  = '0;
      end else if (p.cmd == CMD_CODE_WR || p.cmd == CMD_CODE_RD ||
                   p.cmd == CMD_SIG_WR || p.cmd == CMD_SIG_RD) begin
        st_nxt.off = st_r.off + 1'b1;
      end
    end

    // strobes that land while a burn is running are dropped
    if (par && stb_rise && st_r.busy_cnt == '0) begin
      if (p.cmd == CMD_ERASE) begin
        st_nxt.code     = {CODE_BYTES{ERASED}};
        if (!st_r.fuse[FUSE_UROW]) begin
          st_nxt.urow = {ROW_BYTES{ERASED}};
        end
        st_nxt.fuse[1:0] = LOCK_OPEN;
        st_nxt.busy_cnt  = TMR_W'(P_ERASE_CYC);
      end else if (p.cmd == CMD_FUSE_WR) begin
        st_nxt.fuse     = p.data | FUSE_RSVD;
        st_nxt.busy_cnt = TMR_W'(P_ERASE_CYC);
      end else if (p.cmd == CMD_CODE_WR || p.cmd == CMD_SIG_WR) begin
        st_nxt.pbuf[st_r.off]  = p.data;
        st_nxt.pmask[st_r.off] = 1'b1;
        st_nxt.pend            = 1'b1;
        st_nxt.pend_sig        = (p.cmd == CMD_SIG_WR);
        st_nxt.idle_cnt        = TMR_W'(P_IDLE_CYC);
      end
    end

    st_nxt.busy_oe = par && (st_nxt.busy_cnt != '0);
    st_nxt.dout    = PULL_HI;
    st_nxt.dout_oe = 1'b0;
    if (par) begin
      if (p.cmd == CMD_CODE_RD) begin
        st_nxt.dout    = st_r.code[{st_r.page, st_r.off}];
        st_nxt.dout_oe = 1'b1;
      end else if (p.cmd == CMD_SIG_RD) begin
        st_nxt.dout_oe = 1'b1;
        if (st_r.page == PG_USER) begin
          st_nxt.dout = st_r.urow[st_r.off];
        end else if (st_r.page == PG_MFR) begin
          st_nxt.dout = mfr_byte(st_r.off);
        end
      end else if (p.cmd == CMD_FUSE_RD) begin
        st_nxt.dout    = st_r.fuse;
        st_nxt.dout_oe = 1'b1;
      end
    end

    if (!ser) begin
      st_nxt.bitc    = '0;
      st_nxt.bytec   = '0;
      st_nxt.miso_oe = 1'b0;
    end else begin
      st_nxt.miso_oe = 1'b1;
      if (sck_rise) begin
        st_nxt.miso = st_r.tx[7];
        st_nxt.tx   = {st_r.tx[6:0], 1'b1};
      end
      if (sck_fall) begin
        rxb         = {st_r.rx[6:0], p.mosi};
        st_nxt.rx   = rxb;
        st_nxt.bitc = st_r.bitc + 3'd1;
        if (st_r.bitc == 3'd7) begin
          if (st_r.bytec == 6'd0) begin
            st_nxt.hdr = rxb;
          end else if (st_r.bytec == 6'd1) begin
            a = {rxb[3:0], a[7:0]};
          end else if (st_r.bytec == 6'd2) begin
            a = {a[11:8], rxb};
          end else begin
            if (st_r.hdr[HDR_WRITE_BIT]) begin
              st_nxt.code[a] = rxb;
            end
            a = {a[ADDR_W-1:OFF_W], a[OFF_W-1:0] + 5'd1};
          end
          st_nxt.saddr = a;
          st_nxt.tx    = st_nxt.code[a];
          last = st_nxt.hdr[HDR_PAGE_BIT] ? 6'(SER_PAGE_PKT - 1) : 6'(SER_BYTE_PKT - 1);
          st_nxt.bytec = (st_r.bytec == last) ? 6'd0 : st_r.bytec + 6'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.s1.stb_n <= 1'b1;
      st_r.s2.stb_n <= 1'b1;
      st_r.stb_q    <= 1'b1;
      st_r.code     <= {CODE_BYTES{ERASED}};
      st_r.urow     <= {ROW_BYTES{ERASED}};
      st_r.fuse     <= FUSE_RST;
      st_r.dout     <= PULL_HI;
      st_r.tx       <= PULL_HI;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// File: hdl/fpp_host.sv
/*
  Programmer end: runs one parallel step or one serial action per request.
  Assumes the device end sits across fpp_if; busy, data and miso are synchronised.
*/
`timescale 1ns/100ps
module fpp_host
  import fpp_pkg::*;
#(
  parameter int P_SCLK_CYC = SCLK_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  fpp_if.host             pin,
  input  wire logic       req_i,
  input  wire fpp_op_type op_i,
  input  wire logic [3:0] cmd_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       strobe_i,
  input  wire logic       read_i,
  input  wire logic       pulse_i,
  input  wire logic       wait_i,
  output wire logic       ack_o,
  output wire logic [7:0] rdata_o,
  output wire logic       busy_o
);
  typedef enum logic [3:0] {H_IDLE, H_SETUP, H_STROBE, H_SETTLE, H_WAITB, H_PULSE, H_HOLD,
                            H_PWR, H_XCLK, H_SH_LO, H_SH_HI, H_EX1, H_EX2, H_DONE}
    fpp_hst_state_type;

  typedef struct packed {
    fpp_hst_state_type state;
    logic [TMR_W-1:0]  cnt;
    logic [4:0]        hcnt;
    logic [9:0]        s1;
    logic [9:0]        s2;
    logic              strobe;
    logic              read;
    logic              pulse;
    logic              waitb;
    logic [7:0]        sh;
    logic [2:0]        bitn;
    logic [3:0]        cmd;
    logic              hv;
    logic              rst;
    logic              osc;
    logic              stb_n;
    logic [7:0]        dout;
    logic              dout_oe;
    logic              sck;
    logic              mosi;
    logic              mosi_oe;
    logic              ack;
    logic [7:0]        rdata;
    logic              busy;
  } fpp_hst_st_type;

  fpp_hst_st_type st_r;
  fpp_hst_st_type st_nxt;

  assign pin.cmd_code     = st_r.cmd;
  assign pin.hv_on        = st_r.hv;
  assign pin.rst_pin      = st_r.rst;
  assign pin.osc_in       = st_r.osc;
  assign pin.wr_strobe_n  = st_r.stb_n;
  assign pin.host_data    = st_r.dout;
  assign pin.host_data_oe = st_r.dout_oe;
  assign pin.sck          = st_r.sck;
  assign pin.mosi         = st_r.mosi;
  assign pin.mosi_oe      = st_r.mosi_oe;
  assign ack_o            = st_r.ack;
  assign rdata_o          = st_r.rdata;
  assign busy_o           = st_r.busy;

  always_comb begin
    logic tdone;
    tdone        = (st_r.cnt == '0);
    st_nxt       = st_r;
    st_nxt.s1    = {pin.data_lvl, pin.busy_lvl, pin.miso_lvl};
    st_nxt.s2    = st_r.s1;
    st_nxt.ack   = 1'b0;
    if (!tdone) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    unique case (st_r.state)
      H_IDLE: begin
        // the request just answered is still up at the edge after ack
        if (req_i && !st_r.ack) begin
          st_nxt.busy = 1'b1;
          unique case (op_i)
            OP_PAR_STEP: begin
              st_nxt.hv      = 1'b1;
              st_nxt.rst     = 1'b1;
              st_nxt.cmd     = cmd_i;
              st_nxt.dout    = wdata_i;
              st_nxt.dout_oe = !read_i;
              st_nxt.strobe  = strobe_i;
              st_nxt.read    = read_i;
              st_nxt.pulse   = pulse_i;
              st_nxt.waitb   = wait_i;
              st_nxt.cnt     = TMR_W'(XPULSE_CYC);
              st_nxt.state   = H_SETUP;
            end
            OP_SER_ENTER: begin
              st_nxt.sck     = 1'b0;
              st_nxt.mosi    = 1'b0;
              st_nxt.mosi_oe = 1'b1;
              st_nxt.hv      = 1'b0;
              st_nxt.rst     = 1'b0;
              st_nxt.osc     = 1'b0;
              st_nxt.cnt     = TMR_W'(PWRUP_CYC);
              st_nxt.state   = H_PWR;
            end
            OP_SER_BYTE: begin
              st_nxt.sh    = wdata_i;
              st_nxt.bitn  = 3'd0;
              st_nxt.cnt   = TMR_W'(SCK_HALF_CYC);
              st_nxt.state = H_SH_LO;
            end
            OP_EXIT: begin
              st_nxt.osc   = 1'b0;
              st_nxt.cnt   = TMR_W'(XPULSE_CYC);
              st_nxt.state = H_EX1;
            end
          endcase
        end
      end
      H_SETUP: if (tdone) begin
        st_nxt.stb_n = !st_r.strobe;
        st_nxt.cnt   = st_r.strobe ? TMR_W'(STROBE_CYC) : TMR_W'(XPULSE_CYC);
        st_nxt.state = st_r.strobe ? H_STROBE : H_SETTLE;
      end
      H_STROBE: if (tdone) begin
        st_nxt.stb_n = 1'b1;
        st_nxt.cnt   = TMR_W'(XPULSE_CYC);
        st_nxt.state = H_SETTLE;
      end
      H_SETTLE: if (tdone) begin
        st_nxt.state = H_WAITB;
      end
      H_WAITB: if (!st_r.waitb || st_r.s2[1]) begin
        if (st_r.read) begin
          st_nxt.rdata = st_r.s2[9:2];
        end
        st_nxt.osc   = st_r.pulse;
        st_nxt.cnt   = TMR_W'(XPULSE_CYC);
        st_nxt.state = st_r.pulse ? H_PULSE : H_DONE;
      end
      H_PULSE: if (tdone) begin
        st_nxt.osc   = 1'b0;
        st_nxt.cnt   = TMR_W'(XPULSE_CYC);
        st_nxt.state = H_HOLD;
      end
      H_HOLD: if (tdone) begin
        st_nxt.state = H_DONE;
      end
      H_PWR: if (tdone) begin
        st_nxt.rst   = 1'b1;
        st_nxt.cnt   = TMR_W'(P_SCLK_CYC);
        st_nxt.hcnt  = '0;
        st_nxt.state = H_XCLK;
      end
      H_XCLK: begin
        // a supplied clock stands in for a crystal, so the shorter wait applies
        st_nxt.hcnt = st_r.hcnt + 5'd1;
        if (st_r.hcnt == 5'(XCLK_HALF_CYC - 1)) begin
          st_nxt.hcnt = '0;
          st_nxt.osc  = !st_r.osc;
        end
        if (tdone) begin
          st_nxt.osc   = 1'b0;
          st_nxt.state = H_DONE;
        end
      end
      H_SH_LO: if (tdone) begin
        st_nxt.sck   = 1'b1;
        st_nxt.mosi  = st_r.sh[7];
        st_nxt.cnt   = TMR_W'(SCK_HALF_CYC);
        st_nxt.state = H_SH_HI;
      end
      H_SH_HI: if (tdone) begin
        st_nxt.sck  = 1'b0;
        st_nxt.sh   = {st_r.sh[6:0], st_r.s2[0]};
        st_nxt.bitn = st_r.bitn + 3'd1;
        st_nxt.cnt  = TMR_W'(SCK_HALF_CYC);
        if (st_r.bitn == 3'd7) begin
          st_nxt.rdata = {st_r.sh[6:0], st_r.s2[0]};
          st_nxt.state = H_DONE;  // packet length is the caller's
        end else begin
          st_nxt.state = H_SH_LO;
        end
      end
      H_EX1: if (tdone) begin
        st_nxt.rst   = 1'b0;
        st_nxt.cnt   = TMR_W'(XPULSE_CYC);
        st_nxt.state = H_EX2;
      end
      H_EX2: if (tdone) begin
        st_nxt.mosi_oe = 1'b0;
        st_nxt.hv      = 1'b0;
        st_nxt.state   = H_DONE;
      end
      H_DONE: begin
        st_nxt.dout_oe = 1'b0;
        st_nxt.ack     = 1'b1;
        st_nxt.busy    = 1'b0;
        st_nxt.state   = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.state <= H_IDLE;
      st_r.stb_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// File: shared/fpp_if.sv
/*
  Pin bundle between the flash device end and the programmer end.
  Resolves the shared data port, the open-drain busy pin and the serial lines.
*/
`timescale 1ns/100ps
interface fpp_if;
  import fpp_pkg::*;
  logic [3:0] cmd_code;
  logic       hv_on;
  logic       rst_pin;
  logic       osc_in;
  logic       wr_strobe_n;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic       busy_pull_oe;
  logic       sck;
  logic       mosi;
  logic       mosi_oe;
  logic       miso;
  logic       miso_oe;
  logic [7:0] data_lvl;
  logic       busy_lvl;
  logic       mosi_lvl;
  logic       miso_lvl;

  // undriven lines float to the pull-up level
  assign data_lvl = dev_data_oe ? dev_data : (host_data_oe ? host_data : PULL_HI);
  assign busy_lvl = !busy_pull_oe;
  assign mosi_lvl = mosi_oe ? mosi : 1'b1;
  assign miso_lvl = miso_oe ? miso : 1'b1;

  modport dev (input cmd_code, hv_on, rst_pin, osc_in, wr_strobe_n, data_lvl, sck, mosi_lvl,
               output dev_data, dev_data_oe, busy_pull_oe, miso, miso_oe);
  modport host (output cmd_code, hv_on, rst_pin, osc_in, wr_strobe_n, host_data, host_data_oe,
                sck, mosi, mosi_oe,
                input data_lvl, busy_lvl, miso_lvl);
endinterface

// File: shared/fpp_pkg.sv
/*
  Constants, codes and types shared by both ends of the flash programming port.
  Assumes a 250 MHz clk_i on each end.
*/
package fpp_pkg;
  localparam int CLK_MHZ       = 250;
  localparam int XPULSE_NS     = 100;
  localparam int XPULSE_CYC    = (XPULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS     = 1000;
  localparam int STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_US       = 150;
  localparam int IDLE_CYC      = IDLE_US * CLK_MHZ;
  localparam int ERASE_MS      = 4;
  localparam int ERASE_CYC     = ERASE_MS * 1000 * CLK_MHZ;
  localparam int PAGE_MS       = 2;
  localparam int PAGE_CYC      = PAGE_MS * 1000 * CLK_MHZ;
  localparam int PWRUP_US      = 10;
  localparam int PWRUP_CYC     = PWRUP_US * CLK_MHZ;
  localparam int SCLK_MS       = 4;
  localparam int SCLK_CYC      = SCLK_MS * 1000 * CLK_MHZ;
  localparam int SCK_HALF_CYC  = 16;
  localparam int XCLK_HALF_CYC = 8;
  localparam int TMR_W         = 20;

  localparam int PAGE_W    = 7;
  localparam int OFF_W     = 5;
  localparam int ADDR_W    = PAGE_W + OFF_W;
  localparam int CODE_BYTES = 4096;
  localparam int ROW_BYTES  = 32;

  localparam logic [3:0] CMD_ERASE   = 4'h1;
  localparam logic [3:0] CMD_LOAD_PG = 4'hD;
  localparam logic [3:0] CMD_CODE_WR = 4'hE;
  localparam logic [3:0] CMD_CODE_RD = 4'hC;
  localparam logic [3:0] CMD_SIG_WR  = 4'h0;
  localparam logic [3:0] CMD_SIG_RD  = 4'h8;
  localparam logic [3:0] CMD_FUSE_WR = 4'hF;
  localparam logic [3:0] CMD_FUSE_RD = 4'h3;

  localparam logic [7:0] ERASED      = 8'hFF;
  localparam logic [7:0] PULL_HI     = 8'hFF;
  localparam logic [7:0] FUSE_RST    = 8'hFF;
  localparam logic [7:0] FUSE_RSVD   = 8'h0C;
  localparam int         FUSE_UROW   = 6;
  localparam logic [1:0] LOCK_OPEN   = 2'h3;
  localparam logic [PAGE_W-1:0] PG_USER = 7'h00;
  localparam logic [PAGE_W-1:0] PG_MFR  = 7'h01;

  localparam int HDR_PAGE_BIT   = 0;
  localparam int HDR_WRITE_BIT  = 1;
  localparam int SER_BYTE_PKT   = 4;
  localparam int SER_PAGE_PKT   = 35;

  typedef enum logic [1:0] {OP_PAR_STEP, OP_SER_ENTER, OP_SER_BYTE, OP_EXIT} fpp_op_type;

  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] data;
    logic       osc;
    logic       stb_n;
    logic       rst;
    logic       hv;
    logic       sck;
    logic       mosi;
  } fpp_pins_type;
endpackage
